// *** verilog/pcl_pkg.sv ***
// Shared constants, timing counts and state types for the parallel
// configuration load sequencer (device end and host end).
// Assumes a 100 MHz system clock on both ends.
package pcl_pkg;

   // System clock rate
   localparam int unsigned CLK_MHZ      = 100;

   // Link widths and stream shape
   localparam int unsigned WORD_W       = 16;
   localparam int unsigned RATIO_W      = 4;
   localparam int unsigned STREAM_WORDS = 16;
   localparam int unsigned WCNT_W       = 8;
   localparam int unsigned CNT_W        = 20;

   typedef logic [CNT_W-1:0]  pcl_cnt_t;
   typedef logic [WCNT_W-1:0] pcl_wcnt_t;
   typedef logic [WORD_W-1:0] pcl_word_t;

   // Request low pulse, least time, rounded up
   localparam int unsigned CFG_LOW_NS   = 2000;
   localparam int unsigned CFG_LOW_CYC  = (CFG_LOW_NS * CLK_MHZ + 999) / 1000;
   // Request low to status and done low, longest time, rounded down
   localparam int unsigned CF2ST0_NS    = 600;
   localparam int unsigned CF2ST0_CYC   = (CF2ST0_NS * CLK_MHZ) / 1000;
   // Status low pulse, least time
   localparam int unsigned STATUS_US    = 268;
   localparam int unsigned STATUS_CYC   = STATUS_US * CLK_MHZ;
   // Request high to first load clock edge when status is not watched
   localparam int unsigned CF2CK_US     = 1506;
   localparam int unsigned CF2CK_CYC    = CF2CK_US * CLK_MHZ;
   // Status high to first load clock edge
   localparam int unsigned ST2CK_US     = 2;
   localparam int unsigned ST2CK_CYC    = ST2CK_US * CLK_MHZ;
   // Fastest load clock period, and four of them before user clock enable
   localparam int unsigned LCLK_MIN_PS  = 8000;
   localparam int unsigned CD2CU_NS     = 4 * LCLK_MIN_PS / 1000;
   localparam int unsigned CD2CU_CYC    = (CD2CU_NS * CLK_MHZ + 999) / 1000;
   // Done high to user mode on the internal oscillator, least time
   localparam int unsigned CD2UM_US     = 175;
   localparam int unsigned CD2UM_CYC    = CD2UM_US * CLK_MHZ;
   // User clock cycles needed for initialization
   localparam int unsigned INIT_CYCLES  = 8576;
   // Host load clock half period in system cycles (160 ns period)
   localparam int unsigned LCLK_HALF    = 8;

   typedef enum logic [2:0] {
      DS_HOLD  = 3'h0,
      DS_WAIT  = 3'h1,
      DS_LOAD  = 3'h2,
      DS_CU    = 3'h3,
      DS_INIT  = 3'h4,
      DS_USER  = 3'h5
   } pcl_dev_state_e;

   typedef enum logic [2:0] {
      HS_IDLE  = 3'h0,
      HS_REQ   = 3'h1,
      HS_WAIT  = 3'h2,
      HS_GAP   = 3'h3,
      HS_SEND  = 3'h4,
      HS_DONE  = 3'h5,
      HS_FAIL  = 3'h6
   } pcl_host_state_e;

endpackage

// *** verilog/pcl_link_if.sv ***
// Configuration link between the host end and the device end.
// The shared open-drain status line is resolved here from both enables.
`timescale 1ns/1ps
interface pcl_link_if;
   logic        cfg_req_n;
   logic        load_clock;
   logic [15:0] data;
   logic        conf_done;
   logic        dev_status_oe;
   logic        host_status_oe;
   logic        status_n;

   // Line is pulled up and falls when either end drives it
   assign status_n = ~(dev_status_oe | host_status_oe);

   modport dev (
      input  cfg_req_n,
      input  load_clock,
      input  data,
      input  status_n,
      output conf_done,
      output dev_status_oe
   );

   modport host (
      output cfg_req_n,
      output load_clock,
      output data,
      output host_status_oe,
      input  status_n,
      input  conf_done
   );
endinterface

// *** verilog/pcl_dev_end.sv ***
// Device end of the parallel configuration load sequencer.
// Samples every link pin on clk_sys through two flip-flops; the host
// must keep the load clock well below half the system clock rate.
`timescale 1ns/1ps

module pcl_dev_end #(
   parameter int unsigned STATUS_CYC   = pcl_pkg::STATUS_CYC,
   parameter int unsigned OSC_INIT_CYC = pcl_pkg::CD2UM_CYC,
   parameter int unsigned USR_INIT_CYC = pcl_pkg::INIT_CYCLES
) (
   input  wire logic                 clk_sys,
   input  wire logic                 resetn,
   pcl_link_if.dev                   link,
   input  wire logic                 wide_mode,
   input  wire logic                 use_user_clk,
   input  wire logic [3:0]           ratio_m1,
   input  wire logic                 user_init_clock,
   output logic                      word_valid,
   output logic [15:0]               word_data,
   output logic                      init_clk_en,
   output logic                      user_mode,
   output logic                      load_error
);

   // Synchroniser stages: request, load clock, status, user clock, data
   logic [19:0]             sync1_q;
   logic [19:0]             sync2_q;
   logic                    lclk_prev_q;
   logic                    uclk_prev_q;
   logic                    cfg_prev_q;

   pcl_pkg::pcl_dev_state_e st_q;
   pcl_pkg::pcl_dev_state_e st_d;
   pcl_pkg::pcl_cnt_t       cnt_q;
   pcl_pkg::pcl_cnt_t       cnt_d;
   pcl_pkg::pcl_wcnt_t      words_q;
   pcl_pkg::pcl_wcnt_t      words_d;
   logic [3:0]              rep_q;
   logic [3:0]              rep_d;
   logic                    done_q;
   logic                    done_d;
   logic                    stat_oe_q;
   logic                    stat_oe_d;
   logic                    wv_q;
   logic                    wv_d;
   pcl_pkg::pcl_word_t      wd_q;
   pcl_pkg::pcl_word_t      wd_d;
   logic                    ice_q;
   logic                    ice_d;
   logic                    um_q;
   logic                    um_d;
   logic                    err_q;
   logic                    err_d;

   logic                    cfg_low;
   logic                    cfg_fall;
   logic                    lclk_rise;
   logic                    uclk_rise;
   logic                    line_low;
   logic [15:0]             data_s;

   // Two flops on every pin; only the second stage feeds logic
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sync1_q     <= 20'hFFFFF;
         sync2_q     <= 20'hFFFFF;
         lclk_prev_q <= 1'b1;
         uclk_prev_q <= 1'b1;
         cfg_prev_q  <= 1'b1;
      end else begin
         sync1_q     <= {link.cfg_req_n, link.load_clock, link.status_n,
                         user_init_clock, link.data};
         sync2_q     <= sync1_q;
         lclk_prev_q <= sync2_q[18];
         uclk_prev_q <= sync2_q[16];
         cfg_prev_q  <= sync2_q[19];
      end
   end

   assign cfg_low   = ~sync2_q[19];
   assign cfg_fall  = cfg_prev_q & ~sync2_q[19];
   assign lclk_rise = ~lclk_prev_q & sync2_q[18];
   assign uclk_rise = ~uclk_prev_q & sync2_q[16];
   assign line_low  = ~sync2_q[17];
   assign data_s    = sync2_q[15:0];

   // Sequencer next state
   always_comb begin
      st_d      = st_q;
      cnt_d     = cnt_q;
      words_d   = words_q;
      rep_d     = rep_q;
      done_d    = done_q;
      stat_oe_d = stat_oe_q;
      wv_d      = 1'b0;
      wd_d      = wd_q;
      ice_d     = ice_q;
      um_d      = um_q;
      err_d     = err_q;
      if (cfg_fall) begin
         // A new request aborts whatever was under way
         st_d      = pcl_pkg::DS_HOLD;
         cnt_d     = '0;
         done_d    = 1'b0;
         stat_oe_d = 1'b1;
         words_d   = '0;
         rep_d     = 4'h0;
         ice_d     = 1'b0;
         um_d      = 1'b0;
         // A line held low in this same cycle still counts as an error if loading was under way
         err_d     = (st_q == pcl_pkg::DS_LOAD) & line_low;
      end else begin
         case (st_q)
            pcl_pkg::DS_HOLD: begin
               // Minimum pulse first, then wait for the request to go high
               if (cnt_q != pcl_pkg::pcl_cnt_t'(STATUS_CYC - 1)) begin
                  cnt_d = cnt_q + 1'b1;
               end else if (!cfg_low) begin
                  stat_oe_d = 1'b0;
                  st_d      = pcl_pkg::DS_WAIT;
               end
            end
            pcl_pkg::DS_WAIT: begin
               // An external hold on the status line delays loading
               if (!line_low) begin
                  st_d = pcl_pkg::DS_LOAD;
               end
            end
            pcl_pkg::DS_LOAD: begin
               if (line_low) begin
                  // Line pulled low mid-stream: flag and restart the pulse
                  err_d     = 1'b1;
                  stat_oe_d = 1'b1;
                  cnt_d     = '0;
                  words_d   = '0;
                  rep_d     = 4'h0;
                  st_d      = pcl_pkg::DS_HOLD;
               end else if (lclk_rise) begin
                  // One word per group of ratio_m1+1 load clock edges
                  rep_d = (rep_q == ratio_m1) ? 4'h0 : rep_q + 4'h1;
                  if (rep_q == 4'h0) begin
                     wv_d    = 1'b1;
                     wd_d    = wide_mode ? data_s : {8'h00, data_s[7:0]};
                     words_d = words_q + 1'b1;
                     if (words_q == pcl_pkg::pcl_wcnt_t'(pcl_pkg::STREAM_WORDS - 1)) begin
                        done_d = 1'b1;
                        cnt_d  = '0;
                        st_d   = pcl_pkg::DS_CU;
                     end
                  end
               end
            end
            pcl_pkg::DS_CU: begin
               if (!use_user_clk) begin
                  st_d = pcl_pkg::DS_INIT;
               end else if (cnt_q == pcl_pkg::pcl_cnt_t'(pcl_pkg::CD2CU_CYC - 1)) begin
                  ice_d = 1'b1;
                  cnt_d = '0;
                  st_d  = pcl_pkg::DS_INIT;
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
            pcl_pkg::DS_INIT: begin
               if (use_user_clk) begin
                  // Count user clock edges, not system cycles
                  if (uclk_rise) begin
                     cnt_d = cnt_q + 1'b1;
                     if (cnt_q == pcl_pkg::pcl_cnt_t'(USR_INIT_CYC - 1)) begin
                        um_d = 1'b1;
                        st_d = pcl_pkg::DS_USER;
                     end
                  end
               end else begin
                  cnt_d = cnt_q + 1'b1;
                  if (cnt_q == pcl_pkg::pcl_cnt_t'(OSC_INIT_CYC - 1)) begin
                     um_d = 1'b1;
                     st_d = pcl_pkg::DS_USER;
                  end
               end
            end
            pcl_pkg::DS_USER: begin
               st_d = pcl_pkg::DS_USER;
            end
            default: begin
               st_d = pcl_pkg::DS_HOLD;
            end
         endcase
      end
   end

   // Sequencer registers; reset behaves like power-up with status low
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_q      <= pcl_pkg::DS_HOLD;
         cnt_q     <= '0;
         words_q   <= '0;
         rep_q     <= 4'h0;
         done_q    <= 1'b0;
         stat_oe_q <= 1'b1;
         wv_q      <= 1'b0;
         wd_q      <= 16'h0000;
         ice_q     <= 1'b0;
         um_q      <= 1'b0;
         err_q     <= 1'b0;
      end else begin
         st_q      <= st_d;
         cnt_q     <= cnt_d;
         words_q   <= words_d;
         rep_q     <= rep_d;
         done_q    <= done_d;
         stat_oe_q <= stat_oe_d;
         wv_q      <= wv_d;
         wd_q      <= wd_d;
         ice_q     <= ice_d;
         um_q      <= um_d;
         err_q     <= err_d;
      end
   end

   // All outputs straight from flops
   assign link.conf_done     = done_q;
   assign link.dev_status_oe = stat_oe_q;
   assign word_valid         = wv_q;
   assign word_data          = wd_q;
   assign init_clk_en        = ice_q;
   assign user_mode          = um_q;
   assign load_error         = err_q;

endmodule // pcl_dev_end

// *** verilog/pcl_host_end.sv ***
// Host end of the parallel configuration load sequencer.
// Makes the request, the load clock (divided from clk_sys) and the data;
// words come in through a two-entry buffer so a slow link stalls the source.
`timescale 1ns/1ps
module pcl_host_end #(
   parameter int unsigned CF2CK_CYC = pcl_pkg::CF2CK_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   pcl_link_if.host         link,
   input  wire logic        start,
   input  wire logic        monitor_status,
   input  wire logic        wide_mode,
   input  wire logic [3:0]  ratio_m1,
   input  wire logic        hold_status,
   input  wire logic        in_valid,
   input  wire logic [15:0] in_data,
   output logic             in_ready,
   output logic             done,
   output logic             fail
);

   localparam int unsigned PER = 2 * pcl_pkg::LCLK_HALF;

   logic [1:0]               sync1_q;
   logic [1:0]               sync2_q;
   pcl_pkg::pcl_word_t       buf_q [2];
   logic                     wp_q;
   logic                     rp_q;
   logic [1:0]               fill_q;
   logic                     push;
   logic                     pop;

   pcl_pkg::pcl_host_state_e st_q;
   pcl_pkg::pcl_host_state_e st_d;
   pcl_pkg::pcl_cnt_t        cnt_q;
   pcl_pkg::pcl_cnt_t        cnt_d;
   logic [4:0]               ph_q;
   logic [4:0]               ph_d;
   logic [3:0]               rep_q;
   logic [3:0]               rep_d;
   pcl_pkg::pcl_wcnt_t       wc_q;
   pcl_pkg::pcl_wcnt_t       wc_d;
   logic                     cfg_n_q;
   logic                     cfg_n_d;
   logic                     lclk_q;
   logic                     lclk_d;
   pcl_pkg::pcl_word_t       dat_q;
   pcl_pkg::pcl_word_t       dat_d;
   logic                     done_q;
   logic                     done_d;
   logic                     fail_q;
   logic                     fail_d;
   logic                     hold_q;

   // Status and done pins pass two flops
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sync1_q <= 2'h1;
         sync2_q <= 2'h1;
      end else begin
         sync1_q <= {link.conf_done, link.status_n};
         sync2_q <= sync1_q;
      end
   end

   // Two-entry word buffer; full drops in_ready so no word is lost
   assign in_ready = (fill_q != 2'h2);
   assign push     = in_valid & in_ready;
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         wp_q   <= 1'b0;
         rp_q   <= 1'b0;
         fill_q <= 2'h0;
      end else begin
         if (push) begin
            buf_q[wp_q] <= in_data;
            wp_q        <= ~wp_q;
         end
         if (pop) begin
            rp_q <= ~rp_q;
         end
         fill_q <= fill_q + {1'b0, push} - {1'b0, pop};
      end
   end

   // Request, wait and send sequence
   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      ph_d    = ph_q;
      rep_d   = rep_q;
      wc_d    = wc_q;
      cfg_n_d = cfg_n_q;
      lclk_d  = lclk_q;
      dat_d   = dat_q;
      done_d  = done_q;
      fail_d  = fail_q;
      pop     = 1'b0;
      case (st_q)
         pcl_pkg::HS_IDLE, pcl_pkg::HS_DONE, pcl_pkg::HS_FAIL: begin
            if (st_q == pcl_pkg::HS_DONE && sync2_q[1]) begin
               done_d = 1'b1;
            end
            if (start) begin
               st_d    = pcl_pkg::HS_REQ;
               cfg_n_d = 1'b0;
               cnt_d   = '0;
               done_d  = 1'b0;
               fail_d  = 1'b0;
               // A failed load may leave the divider mid-word
               ph_d    = 5'h00;
               rep_d   = 4'h0;
               wc_d    = '0;
            end
         end
         pcl_pkg::HS_REQ: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == pcl_pkg::pcl_cnt_t'(pcl_pkg::CFG_LOW_CYC - 1)) begin
               cfg_n_d = 1'b1;
               cnt_d   = '0;
               st_d    = pcl_pkg::HS_WAIT;
            end
         end
         pcl_pkg::HS_WAIT: begin
            cnt_d = cnt_q + 1'b1;
            if (monitor_status && sync2_q[0]) begin
               cnt_d = '0;
               st_d  = pcl_pkg::HS_GAP;
            end else if (!monitor_status && cnt_q == pcl_pkg::pcl_cnt_t'(CF2CK_CYC - 1)) begin
               cnt_d = '0;
               st_d  = pcl_pkg::HS_SEND;
            end
         end
         pcl_pkg::HS_GAP: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == pcl_pkg::pcl_cnt_t'(pcl_pkg::ST2CK_CYC - 1)) begin
               st_d = pcl_pkg::HS_SEND;
            end
         end
         pcl_pkg::HS_SEND: begin
            // Abort only while the clock is low so no runt high pulse goes out
            if (monitor_status && !sync2_q[0] && !lclk_q) begin
               fail_d = 1'b1;
               lclk_d = 1'b0;
               st_d   = pcl_pkg::HS_FAIL;
            end else if (ph_q == 5'h00 && rep_q == 4'h0) begin
               // New word while the clock is low; stall if buffer empty
               if (wc_q == pcl_pkg::pcl_wcnt_t'(pcl_pkg::STREAM_WORDS)) begin
                  wc_d = '0;
                  st_d = pcl_pkg::HS_DONE;
               end else if (fill_q != 2'h0) begin
                  pop   = 1'b1;
                  dat_d = wide_mode ? buf_q[rp_q] : {8'h00, buf_q[rp_q][7:0]};
                  ph_d  = 5'h01;
               end
            end else begin
               // Fixed divider keeps the period at PER cycles
               ph_d   = (ph_q == 5'(PER - 1)) ? 5'h00 : ph_q + 5'h01;
               lclk_d = (ph_d >= 5'(pcl_pkg::LCLK_HALF));
               if (ph_q == 5'(PER - 1)) begin
                  rep_d = (rep_q == ratio_m1) ? 4'h0 : rep_q + 4'h1;
                  if (rep_q == ratio_m1) begin
                     wc_d = wc_q + 1'b1;
                  end
               end
            end
         end
         default: begin
            st_d = pcl_pkg::HS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_q    <= pcl_pkg::HS_IDLE;
         cnt_q   <= '0;
         ph_q    <= 5'h00;
         rep_q   <= 4'h0;
         wc_q    <= '0;
         cfg_n_q <= 1'b1;
         lclk_q  <= 1'b0;
         dat_q   <= 16'h0000;
         done_q  <= 1'b0;
         fail_q  <= 1'b0;
         hold_q  <= 1'b0;
      end else begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         ph_q    <= ph_d;
         rep_q   <= rep_d;
         wc_q    <= wc_d;
         cfg_n_q <= cfg_n_d;
         lclk_q  <= lclk_d;
         dat_q   <= dat_d;
         done_q  <= done_d;
         fail_q  <= fail_d;
         hold_q  <= hold_status;
      end
   end

   assign link.cfg_req_n      = cfg_n_q;
   assign link.load_clock     = lclk_q;
   assign link.data           = dat_q;
   assign link.host_status_oe = hold_q;
   assign done                = done_q;
   assign fail                = fail_q;

endmodule // pcl_host_end

// *** bench/pcl_chk.sv ***
// Checker for the link between the host end and the device end.
// Sees only the link signals; the bench places it beside the link.
`timescale 1ns/1ps
module pcl_chk #(
   parameter int unsigned STATUS_CYC = 50,
   parameter int unsigned CF2CK_CYC  = 100
) (
   input wire logic        clk_sys,
   input wire logic        resetn,
   input wire logic        cfg_req_n,
   input wire logic        load_clock,
   input wire logic [15:0] data,
   input wire logic        conf_done,
   input wire logic        dev_status_oe,
   input wire logic        host_status_oe,
   input wire logic        status_n
);
   localparam int T_ST0   = 60;
   localparam int REL_MAX = 281;
   logic        lc_q;
   logic [19:0] low_q, low_d, oe_q, oe_d, rel_q, rel_d, st_q, st_d, cf_q, cf_d, edg_q, edg_d;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   // Cycle counts; 20 bits outlast the whole run, so they never wrap
   always_comb begin
      low_d = cfg_req_n ? '0 : low_q + 20'h1;
      oe_d  = dev_status_oe ? oe_q + 20'h1 : '0;
      rel_d = (dev_status_oe && cfg_req_n) ? rel_q + 20'h1 : '0;
      st_d  = status_n ? st_q + 20'h1 : '0;
      cf_d  = cfg_req_n ? cf_q + 20'h1 : '0;
      edg_d = !cfg_req_n ? '0 : edg_q + 20'(load_clock && !lc_q);
   end

   // Counter registers
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         {lc_q, low_q, oe_q, rel_q, st_q, cf_q, edg_q} <= '0;
      end else begin
         {lc_q, low_q, oe_q, rel_q, st_q, cf_q, edg_q} <= {load_clock, low_d, oe_d, rel_d, st_d, cf_d, edg_d};
      end
   end

   sequence s_req_fall;
      $fell(cfg_req_n);
   endsequence
   sequence s_clk_rise;
      $rose(load_clock);
   endsequence
   sequence s_clk_high;
      load_clock [*4];
   endsequence

   chk_req_width: assert property ($rose(cfg_req_n) |-> low_q >= pcl_pkg::CFG_LOW_CYC)
      else $error("request low pulse too short");
   chk_done_clear: assert property (s_req_fall |-> ##[0:T_ST0] !conf_done)
      else $error("done not cleared after request");
   chk_status_pull: assert property (s_req_fall |-> ##[0:T_ST0] dev_status_oe)
      else $error("status not pulled after request");
   chk_status_min: assert property ($fell(dev_status_oe) |-> oe_q >= STATUS_CYC - 1)
      else $error("status pulse too short");
   chk_status_rel: assert property (dev_status_oe && cfg_req_n |-> rel_q < REL_MAX)
      else $error("status held too long after request high");
   chk_first_clk: assert property (s_clk_rise |-> st_q >= pcl_pkg::ST2CK_CYC || cf_q >= CF2CK_CYC - 1)
      else $error("load clock too early");
   chk_data_steady: assert property ($changed(data) |-> !load_clock)
      else $error("data moved while load clock high");
   chk_clk_width: assert property (s_clk_rise |-> s_clk_high)
      else $error("load clock high time too short");
   chk_done_stream: assert property ($rose(conf_done) |-> edg_q >= pcl_pkg::STREAM_WORDS)
      else $error("done before full stream");
endmodule // pcl_chk

// *** bench/test_parallel_config_load_sequencer.sv ***
// Bench for the link: host end feeds the device end through the interface.
// Assumes shortened counts set at the instances below.
`timescale 1ns/1ps
module test_parallel_config_load_sequencer;
   logic        clk_sys = 0, resetn = 0, start = 0, mon = 0, wide = 0, uclk = 0;
   logic        hold = 0, in_valid = 0, ucc = 0;
   logic [3:0]  ratio = 0;
   logic [15:0] in_data = 0, word_data;
   logic        in_ready, done, fail, word_valid, init_clk_en, user_mode, load_error;
   int          err_count = 0, checks = 0, urise = 0, stalls = 0;
   int          ur1 = 0, ur2 = 0, ur3 = 0;
   logic [15:0] got[$];

   pcl_link_if lk ();
   pcl_host_end #(.CF2CK_CYC(100)) pcl_host_end_i (.clk_sys, .resetn, .link(lk), .start, .monitor_status(mon),
      .wide_mode(wide), .ratio_m1(ratio), .hold_status(hold), .in_valid, .in_data, .in_ready, .done, .fail);
   pcl_dev_end #(.STATUS_CYC(50), .OSC_INIT_CYC(40), .USR_INIT_CYC(20)) pcl_dev_end_i (.clk_sys, .resetn,
      .link(lk), .wide_mode(wide), .use_user_clk(uclk), .ratio_m1(ratio), .user_init_clock(ucc),
      .word_valid, .word_data, .init_clk_en, .user_mode, .load_error);
   // Checker defaults already carry the shortened counts
   pcl_chk pcl_chk_i (.clk_sys, .resetn, .cfg_req_n(lk.cfg_req_n),
      .load_clock(lk.load_clock), .data(lk.data), .conf_done(lk.conf_done), .dev_status_oe(lk.dev_status_oe),
      .host_status_oe(lk.host_status_oe), .status_n(lk.status_n));

   // System clock, and a 160 ns user init clock unrelated in phase
   initial forever #5 clk_sys = ~clk_sys;
   initial begin
      #3;
      forever #80 ucc = ~ucc;
   end
   always @(posedge ucc) urise++;
   // Same sync lag plus edge stage as the device, so rise counts line up
   always @(posedge clk_sys) begin
      ur1 <= urise;
      ur2 <= ur1;
      ur3 <= ur2;
   end
   // Words the device hands out, kept for comparison; sampled mid-cycle
   always @(negedge clk_sys) if (word_valid === 1'b1) got.push_back(word_data);

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   function automatic logic pick(input int s);
      logic [5:0] v;
      v = {fail, load_error, user_mode, init_clk_en, lk.conf_done, done};
      return v[s];
   endfunction

   // Bounded wait for one flag; n gives the cycles taken
   task automatic wait_for(input int s, output int n);
      n = 0;
      while (n < 3000 && pick(s) !== 1'b1) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 3000) err_count++;
   endtask

   // Offers one word and holds it until the buffer takes it; valid stays up
   task automatic push(input logic [15:0] w);
      int n;
      n = 0;
      in_valid = 1'b1;
      in_data = w;
      while (in_ready !== 1'b1 && n < 2000) begin
         @(negedge clk_sys);
         n++;
         stalls++;
      end
      if (n >= 2000) err_count++;
      @(negedge clk_sys);
   endtask

   // Starts a load and pushes nw words of a known pattern
   task automatic run_load(input logic m, input logic w, input logic [3:0] r, input logic u, input int nw);
      got.delete();
      @(negedge clk_sys);
      mon = m;
      wide = w;
      ratio = r;
      uclk = u;
      start = 1'b1;
      @(negedge clk_sys);
      start = 1'b0;
      for (int i = 0; i < nw; i++) push(16'hA5C3 ^ 16'(i * 16'h1111));
      in_valid = 1'b0;
   endtask

   // Byte mode keeps only the low byte; upper byte must read zero
   task automatic check_words(input logic w);
      logic [15:0] e;
      check(16'(got.size()), 16'h0010);
      foreach (got[i]) begin
         e = 16'hA5C3 ^ 16'(i * 16'h1111);
         check(got[i], w ? e : {8'h00, e[7:0]});
      end
   endtask

   // Blind host, byte words, internal init count
   task automatic t_blind_byte();
      int n;
      stalls = 0;
      run_load(1'b0, 1'b0, 4'h0, 1'b0, 16);
      wait_for(1, n);
      wait_for(2 + 1, n);
      check(16'(n >= 40 && n <= 99), 16'h0001);
      check({15'h0, done}, 16'h0001);
      check_words(1'b0);
      check(16'(stalls > 0), 16'h0001); // full buffer refused words
   endtask

   // Watching host, wide words held three load clocks, user clock init
   task automatic t_watch_wide();
      int n, u0;
      run_load(1'b1, 1'b1, 4'h2, 1'b1, 16);
      wait_for(1, n);
      wait_for(2, n);
      u0 = ur3;
      check(16'(n >= 3 && n <= 6), 16'h0001);
      wait_for(3, n);
      check(16'(ur3 - u0 >= 20 && ur3 - u0 <= 21), 16'h0001);
      check_words(1'b1);
   endtask

   // Host pulls status low mid-load: error raised, no completion
   task automatic t_status_err();
      int n;
      run_load(1'b1, 1'b1, 4'h0, 1'b0, 6);
      hold = 1'b1;
      wait_for(4, n);
      check({15'h0, load_error}, 16'h0001);
      wait_for(5, n);
      check({15'h0, fail}, 16'h0001);
      check({15'h0, lk.conf_done}, 16'h0000);
      @(negedge clk_sys);
      hold = 1'b0;
   endtask

   // Watchdog, well beyond the few thousand cycles the tests take
   initial begin
      #200000;
      err_count++;
      stop_test();
   end

   initial begin
      repeat (16) @(negedge clk_sys);
      resetn = 1'b1;
      t_blind_byte();
      t_watch_wide();
      t_status_err();
      stop_test();
   end
endmodule // test_parallel_config_load_sequencer
